// ==== nog_guard.sv ====
// Option shadow, map configuration, security and program/erase guard logic.
// Assumes nonvolatile bytes, key writes and command launches come from logic
// on the same bus clock; the debug flag marks accesses made by background debug.
//
// Summary of operation
// - Each reset, copy the nonvolatile options byte into options_shadow.
// - options_shadow cannot be written; changes need reprogramming plus reset.
// - With backdoor_unlock_enable at 0, key comparison never lifts security.
// - Eight matching key bytes in order lift security until next reset.
// - Key bytes from background debug are refused.
// - Options bit 6 at 1 disables vector redirection.
// - Options bit 5 selects EEPROM sector mode, split or whole page.
// - Lock code 1:0 means unsecured; every other code means secure.
// - While secure, accesses from unsecured sources are blocked.
// - Key match or confirmed blank Flash forces lock code to 1:0.
// - map_config bit 6 chooses the foreground EEPROM page.
// - map_config bit 5 steers key-window writes to command or key capture.
// - Each reset, load program_guard from the nonvolatile protection byte.
// - program_guard is always readable; non-debug writes that shrink protection are ignored.
// - Program or erase inside a protected range is refused, flag set.
// - Mass erase is refused while any sector is protected.
// - EEPROM guard field codes 3,2,1,0 protect none, 16, 32, 64 bytes up to 0x17FF.
// - Flash guard 0x3F none, 0x3E from 0xFA00, 0x18 and below everything.
// - Background debug may rewrite program_guard freely, even reducing it.
// - Clearing key-write enable after eight bytes triggers the comparison.
// - Protection violation flag holds until software writes one to it.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module nog_guard (
    // Clock, reset and enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Source of the current bus access
    input  wire logic                 dbg_access,
    // Nonvolatile contents
    input  wire logic [7:0]           nonvolatile_options_byte,
    input  wire logic [7:0]           nonvolatile_protection_byte,
    input  wire logic [63:0]          backdoor_compare_key,
    // Key window writes and command launches
    input  wire nog_pkg::nog_key_wr_t key_wr,
    input  wire nog_pkg::nog_cmd_t    cmd,
    input  wire logic                 blank_check_ok,
    // Status and steering outputs
    output logic                      key_cmd_start,
    output logic                      cmd_accept,
    output logic                      cmd_reject,
    output logic                      protection_violation_flag,
    output logic                      secure,
    output logic                      unsecured_block,
    output logic                      vector_redirect_disable,
    output logic                      eeprom_sector_mode,
    output logic                      eeprom_page_choose
);
    import nog_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic                 loaded;
    logic [7:0]           options_shadow;
    logic                 unlocked;
    logic [7:0]           map_config;
    logic [7:0]           program_guard;
    nog_key_state_t       key_state;
    logic [3:0]           key_cnt;
    logic                 key_bad;
    logic [7:0]           key_buf [8];
    logic [7:0]           key_hit;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 map_wr;
    logic                 guard_wr;
    logic                 viol_clr;
    logic                 key_win;
    logic                 guard_grow;
    logic                 ee_prot;
    logic                 fl_prot;
    logic                 any_prot;
    logic                 cmd_prot;
    logic [16:0]          fl_low;
    logic [15:0]          ee_low;

    // Bus decode; a write lands on the edge that raises ack
    // Masking with ack keeps a held request from being taken a second time
    assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
    assign map_wr   = bus_wr & (wb_adr_i == OFS_MAP);
    assign guard_wr = bus_wr & (wb_adr_i == OFS_GUARD);
    assign viol_clr = bus_wr & (wb_adr_i == OFS_STATUS) & wb_dat_i[STAT_VIOL_BIT];
    assign key_win  = key_wr.wr & (key_wr.addr[15:3] == KEY_BASE[15:3]);

    // Numeric compare per field: a lower code never protects less
    assign guard_grow = (wb_dat_i[7:6] <= program_guard[7:6])
                      & (wb_dat_i[5:0] <= program_guard[5:0]);

    // Lower bound of protected Flash grows by one sector pair per code step
    // Low codes wrap in 17 bits here; fl_prot ignores fl_low for them
    assign fl_low = FLASH_TOP - 17'(17'(FPS_NONE - program_guard[5:0]) * FLASH_STEP);

    // EEPROM guard bound from the two-bit field
    // Code 3 protects nothing; ee_prot masks it, so the default bound is unused
    always_comb begin
        unique case (program_guard[7:6])
            2'h2:    ee_low = EE_LOW_EPS2;
            2'h1:    ee_low = EE_LOW_EPS1;
            2'h0:    ee_low = EE_LOW_EPS0;
            default: ee_low = EE_END;
        endcase
    end

    // Range checks for the launched command
    assign ee_prot  = (program_guard[7:6] != EPS_NONE)
                    & (cmd.addr >= ee_low) & (cmd.addr <= EE_END);
    assign fl_prot  = (program_guard[5:0] <= FPS_ALL_MAX)
                    | ((program_guard[5:0] != FPS_NONE)
                       & ({1'b0, cmd.addr} >= fl_low));
    assign any_prot = (program_guard[7:6] != EPS_NONE)
                    | (program_guard[5:0] != FPS_NONE);
    assign cmd_prot = cmd.mass ? any_prot : (cmd.eeprom ? ee_prot : fl_prot);

    // Per-byte key comparison, byte 0 of the window in the low key byte
    for (genvar i = 0; i < 8; i++) begin : g_key
        assign key_hit[i] = (key_buf[i] == backdoor_compare_key[8*i +: 8]);
    end

    // Security, options and load after reset
    // Unlock is kept apart from options_shadow so the loaded image never changes
    logic       next_loaded;
    logic [7:0] next_options_shadow;
    logic       next_unlocked;
    logic       next_secure;
    logic       key_match;

    assign key_match = (key_state == NOG_KEY_CHECK) & (key_cnt == KEY_BYTES) & ~key_bad
                     & (&key_hit) & options_shadow[OPT_KEY_EN_BIT];

    always_comb begin
        next_loaded         = 1'b1;
        next_options_shadow = options_shadow;
        next_unlocked       = unlocked;
        if (!loaded) begin
            next_options_shadow = nonvolatile_options_byte;
        end
        if (loaded && (key_match || blank_check_ok)) begin
            next_unlocked = 1'b1;
        end
        next_secure = ~next_unlocked & (next_options_shadow[1:0] != SEC_OPEN);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loaded          <= 1'b0;
            options_shadow  <= OPT_RST;
            unlocked        <= 1'b0;
            secure          <= 1'b1;
            unsecured_block <= 1'b1;
        end else if (ce) begin
            loaded          <= next_loaded;
            options_shadow  <= next_options_shadow;
            unlocked        <= next_unlocked;
            secure          <= next_secure;
            unsecured_block <= next_secure;
        end
    end

    // Options are frozen once loaded; only a fresh reset reloads them
    opt_fixed_a: assert property (loaded && $past(loaded) |-> $stable(options_shadow));
    opt_load_a: assert property ($rose(loaded)
        |-> options_shadow == $past(nonvolatile_options_byte));
    sec_decode_a: assert property (loaded |-> secure == (!unlocked
        && options_shadow[1:0] != SEC_OPEN));
    ublk_same_a: assert property (unsecured_block == secure);
    opt_copy_a: assert property (loaded
        |-> vector_redirect_disable == options_shadow[OPT_NORED_BIT]
        && eeprom_sector_mode == options_shadow[OPT_SECMODE_BIT]);
    // Unlock paths: blank check always, the key only with its enable bit set
    blank_unlock_a: assert property (ce && loaded && blank_check_ok
        |=> !secure && !unsecured_block);
    key_gate_a: assert property (ce && !unlocked && !options_shadow[OPT_KEY_EN_BIT]
        && !blank_check_ok |=> !unlocked);

    // Map configuration, guard register and violation flag
    logic [7:0] next_map_config;
    logic [7:0] next_program_guard;
    logic       next_viol;

    always_comb begin
        next_map_config    = map_config;
        next_program_guard = program_guard;
        next_viol          = protection_violation_flag;
        if (map_wr) begin
            next_map_config = {1'b0, wb_dat_i[MAP_PAGE_BIT], wb_dat_i[MAP_COMPARE_KEY_WRITE_ENABLE_BIT], 5'h00};
        end
        if (!loaded) begin
            next_program_guard = nonvolatile_protection_byte;
        end else if (guard_wr && (dbg_access || guard_grow)) begin
            next_program_guard = wb_dat_i[7:0];
        end
        if (viol_clr) begin
            next_viol = 1'b0;
        end
        if (cmd.launch && cmd_prot) begin
            next_viol = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            map_config                <= MAP_RST;
            program_guard             <= GUARD_RST;
            protection_violation_flag <= 1'b0;
            cmd_accept                <= 1'b0;
            cmd_reject                <= 1'b0;
            key_cmd_start             <= 1'b0;
            vector_redirect_disable   <= 1'b0;
            eeprom_sector_mode        <= 1'b0;
            eeprom_page_choose        <= 1'b0;
        end else if (ce) begin
            map_config                <= next_map_config;
            program_guard             <= next_program_guard;
            protection_violation_flag <= next_viol;
            cmd_accept                <= cmd.launch & ~cmd_prot;
            cmd_reject                <= cmd.launch & cmd_prot;
            key_cmd_start             <= key_win & ~map_config[MAP_COMPARE_KEY_WRITE_ENABLE_BIT];
            vector_redirect_disable   <= next_options_shadow[OPT_NORED_BIT];
            eeprom_sector_mode        <= next_options_shadow[OPT_SECMODE_BIT];
            eeprom_page_choose        <= next_map_config[MAP_PAGE_BIT];
        end
    end

    // A non-debug write that raises the EEPROM code would shrink protection
    guard_shrink_a: assert property (ce && loaded && guard_wr && !dbg_access
        && wb_dat_i[7:6] > program_guard[7:6] |=> $stable(program_guard));
    guard_load_a: assert property ($rose(loaded)
        |-> program_guard == $past(nonvolatile_protection_byte));
    dbg_guard_a: assert property (ce && loaded && guard_wr && dbg_access
        |=> program_guard == $past(wb_dat_i[7:0]));
    viol_set_a: assert property (ce && cmd.launch && cmd_prot
        |=> cmd_reject && !cmd_accept && protection_violation_flag);
    mass_reject_a: assert property (ce && cmd.launch && cmd.mass
        && program_guard != 8'hFF |=> cmd_reject);
    viol_hold_a: assert property (protection_violation_flag && !viol_clr
        |=> protection_violation_flag);
    viol_clear_a: assert property (ce && viol_clr && !(cmd.launch && cmd_prot)
        |=> !protection_violation_flag);
    key_steer_a: assert property (ce && key_win && !map_config[MAP_COMPARE_KEY_WRITE_ENABLE_BIT]
        |=> key_cmd_start);
    page_copy_a: assert property (eeprom_page_choose == map_config[MAP_PAGE_BIT]);
    // Table end points, checked apart from the step arithmetic of the bound
    fl_all_a: assert property (ce && cmd.launch && !cmd.mass && !cmd.eeprom
        && program_guard[5:0] <= FPS_ALL_MAX |=> cmd_reject);
    fl_open_a: assert property (ce && cmd.launch && !cmd.mass && !cmd.eeprom
        && program_guard[5:0] == FPS_NONE |=> cmd_accept);
    ee_top_a: assert property (ce && cmd.launch && !cmd.mass && cmd.eeprom
        && program_guard[7:6] != EPS_NONE && cmd.addr == EE_END |=> cmd_reject);
    ee_open_a: assert property (ce && cmd.launch && !cmd.mass && cmd.eeprom
        && program_guard[7:6] == EPS_NONE |=> cmd_accept);

    // Key capture state machine
    // A spoilt attempt still runs through the check state, so it ends cleanly
    nog_key_state_t next_key_state;
    logic [3:0]     next_key_cnt;
    logic           next_key_bad;
    logic [7:0]     next_key_buf [8];

    always_comb begin
        next_key_state = key_state;
        next_key_cnt   = key_cnt;
        next_key_bad   = key_bad;
        next_key_buf   = key_buf;
        unique case (key_state)
            NOG_KEY_IDLE: begin
                if (map_wr && wb_dat_i[MAP_COMPARE_KEY_WRITE_ENABLE_BIT]) begin
                    next_key_state = NOG_KEY_COLLECT;
                    next_key_cnt   = 4'h0;
                    next_key_bad   = 1'b0;
                end
            end
            NOG_KEY_COLLECT: begin
                // Out-of-order or debug bytes spoil the whole sequence
                if (key_win && map_config[MAP_COMPARE_KEY_WRITE_ENABLE_BIT]) begin
                    if (key_wr.debug || key_cnt >= KEY_BYTES
                        || key_wr.addr[2:0] != key_cnt[2:0]) begin
                        next_key_bad = 1'b1;
                    end else begin
                        next_key_buf[key_cnt[2:0]] = key_wr.data;
                        next_key_cnt               = key_cnt + 4'h1;
                    end
                end
                if (map_wr && !wb_dat_i[MAP_COMPARE_KEY_WRITE_ENABLE_BIT]) begin
                    next_key_state = NOG_KEY_CHECK;
                end
            end
            NOG_KEY_CHECK: begin
                next_key_state = NOG_KEY_IDLE;
            end
            default: begin
                next_key_state = NOG_KEY_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            key_state <= NOG_KEY_IDLE;
            key_cnt   <= 4'h0;
            key_bad   <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                key_buf[i] <= 8'h00;
            end
        end else if (ce) begin
            key_state <= next_key_state;
            key_cnt   <= next_key_cnt;
            key_bad   <= next_key_bad;
            key_buf   <= next_key_buf;
        end
    end

    key_dbg_a: assert property (ce && key_state == NOG_KEY_COLLECT && key_win
        && map_config[MAP_COMPARE_KEY_WRITE_ENABLE_BIT] && key_wr.debug |=> key_bad);
    key_check_a: assert property (ce && key_state == NOG_KEY_CHECK
        && key_cnt != KEY_BYTES && !blank_check_ok && !unlocked |=> !unlocked);
    // A clean key sequence must open the device at the next edge
    key_open_a: assert property (ce && loaded && key_match
        |=> unlocked && !secure);

    // Wishbone answer: ack one cycle after the request, data registered with it
    // Data is zero outside the ack cycle, so stale read data is never seen
    logic [31:0] next_dat;

    always_comb begin
        next_dat = 32'h0000_0000;
        unique case (wb_adr_i)
            OFS_OPTIONS: next_dat = {24'h00_0000, options_shadow[7:2],
                                     unlocked ? SEC_OPEN : options_shadow[1:0]};
            OFS_MAP:     next_dat = {24'h00_0000, map_config};
            OFS_GUARD:   next_dat = {24'h00_0000, program_guard};
            OFS_STATUS:  next_dat = {26'h000_0000, protection_violation_flag, 4'h0, secure};
            default:     next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_dat : 32'h0000_0000;
        end
    end

    ack_pulse_a: assert property (ce && wb_ack_o |=> !wb_ack_o);

    // Main paths: key unlock, refused program, debug shrink, blank-check unlock
    unlock_key_c: cover property (ce && key_match);
    viol_c: cover property (ce && cmd.launch && cmd_prot && !cmd.mass);
    dbg_shrink_c: cover property (ce && guard_wr && dbg_access && !guard_grow);
    blank_c: cover property (ce && loaded && blank_check_ok && secure);

endmodule

`default_nettype wire

// ==== nog_pkg.sv ====
// Package for the option, map-configuration and program/erase guard block.
// Assumes a single bus clock; all users import the whole package.
package nog_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFS_OPTIONS = 8'h00;
    localparam logic [7:0] OFS_MAP     = 8'h04;
    localparam logic [7:0] OFS_GUARD   = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;

    // Field positions in options_shadow
    localparam int OPT_KEY_EN_BIT  = 7;
    localparam int OPT_NORED_BIT   = 6;
    localparam int OPT_SECMODE_BIT = 5;
    localparam logic [1:0] SEC_OPEN = 2'h2;

    // Field positions in map_config and status
    localparam int MAP_PAGE_BIT   = 6;
    localparam int MAP_COMPARE_KEY_WRITE_ENABLE_BIT = 5;
    localparam int STAT_VIOL_BIT  = 5;
    localparam int STAT_SEC_BIT   = 0;

    // Values held during reset, before the nonvolatile bytes are loaded
    localparam logic [7:0] OPT_RST   = 8'h00;
    localparam logic [7:0] MAP_RST   = 8'h00;
    localparam logic [7:0] GUARD_RST = 8'h00;

    // Guard field encodings and protected ranges
    localparam logic [1:0]  EPS_NONE     = 2'h3;
    localparam logic [5:0]  FPS_NONE     = 6'h3F;
    localparam logic [5:0]  FPS_ALL_MAX  = 6'h18;
    localparam logic [16:0] FLASH_TOP    = 17'h10000;
    localparam logic [16:0] FLASH_STEP   = 17'h00600;
    localparam logic [15:0] EE_END       = 16'h17FF;
    localparam logic [15:0] EE_LOW_EPS2  = 16'h17F0;
    localparam logic [15:0] EE_LOW_EPS1  = 16'h17E0;
    localparam logic [15:0] EE_LOW_EPS0  = 16'h17C0;

    // Backdoor key window
    localparam logic [15:0] KEY_BASE  = 16'hFFB0;
    localparam logic [3:0]  KEY_BYTES = 4'h8;

    typedef enum logic [1:0] {
        NOG_KEY_IDLE    = 2'h0,
        NOG_KEY_COLLECT = 2'h1,
        NOG_KEY_CHECK   = 2'h3
    } nog_key_state_t;

    // Write to the key address window
    typedef struct packed {
        logic        wr;
        logic        debug;
        logic [15:0] addr;
        logic [7:0]  data;
    } nog_key_wr_t;

    // Program or erase command launch
    typedef struct packed {
        logic        launch;
        logic        mass;
        logic        eeprom;
        logic [15:0] addr;
    } nog_cmd_t;

endpackage

// ==== tb_top.sv ====
// Self-checking bench for the option, map and program/erase guard block.
// Assumes nog_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import nog_pkg::*;

    // Arbitrary stored key, byte 0 in the low bits
    localparam logic [63:0] KEY = 64'h0F1E2D3C4B5A6978;

    logic        clk = 1'b0;
    logic        rst, ce, cyc, stb, we, dbg, blank_ok;
    logic [7:0]  adr, nv_opt, nv_prot, rd;
    logic [31:0] dat, dat_o;
    logic [3:0]  sel;
    logic        ack, kstart, acc, rej, viol, secure, ublk, nored, smode, page;
    nog_key_wr_t key_wr;
    nog_cmd_t    cmd;
    int          miscompares, cmp_count;
    logic        flag_exp = 1'b0;
    logic [5:0]  fcode [8] = '{6'h3E, 6'h3D, 6'h37, 6'h30, 6'h2A, 6'h1F, 6'h19, 6'h18};
    // Lowest protected Flash address per code; 0x30 lies between listed rows
    logic [15:0] flow [8] = '{16'hFA00, 16'hF400, 16'hD000, 16'hA600, 16'h8200, 16'h4000,
                              16'h1C00, 16'h0000};
    logic [15:0] ee_low [4] = '{16'h17C0, 16'h17E0, 16'h17F0, 16'h0000};

    // 100 MHz bus clock
    always #5 clk = ~clk;

    nog_guard dut (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .dbg_access(dbg), .nonvolatile_options_byte(nv_opt),
        .nonvolatile_protection_byte(nv_prot), .backdoor_compare_key(KEY),
        .key_wr(key_wr), .cmd(cmd), .blank_check_ok(blank_ok), .key_cmd_start(kstart),
        .cmd_accept(acc), .cmd_reject(rej), .protection_violation_flag(viol),
        .secure(secure), .unsecured_block(ublk), .vector_redirect_disable(nored),
        .eeprom_sector_mode(smode), .eeprom_page_choose(page));

    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic single cycle; ack is sampled on the rising edge, read data is
    // taken at that same edge, and only then is the request released
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                           input logic dg);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d}; dbg <= dg;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            miscompares++;
            close_out();
        end else begin
            rd = dat_o[7:0];
            cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; dbg <= 1'b0;
        end
    endtask

    task automatic wb_rd(input logic [7:0] a, input logic [7:0] exp, input logic dg);
        wb_xfer(1'b0, a, 8'h00, dg);
        check(rd, exp);
    endtask

    // One-cycle command launch; the answer stands in the following cycle
    task automatic launch(input logic m, input logic e, input logic [15:0] a,
                          input logic exp_rej);
        @(posedge clk);
        cmd <= '{launch: 1'b1, mass: m, eeprom: e, addr: a};
        @(posedge clk);
        cmd.launch <= 1'b0;
        flag_exp = flag_exp | exp_rej;
        @(negedge clk);
        check({5'h0, rej, acc, viol}, {5'h0, exp_rej, ~exp_rej, flag_exp});
    endtask

    task automatic key_byte(input int i, input logic dg, input logic exp_start);
        @(posedge clk);
        key_wr <= '{wr: 1'b1, debug: dg, addr: KEY_BASE + 16'(i), data: KEY[8*i+:8]};
        @(posedge clk);
        key_wr.wr <= 1'b0;
        @(negedge clk);
        check(8'(kstart), 8'(exp_start));
    endtask

    // Full key sequence; unlock lands one edge after the edge that takes the clearing write
    task automatic key_seq(input logic dg, input logic exp_secure);
        wb_xfer(1'b1, OFS_MAP, 8'h20, 1'b0);
        for (int i = 0; i < 8; i++) begin
            key_byte(i, dg, 1'b0);
        end
        wb_xfer(1'b1, OFS_MAP, 8'h00, 1'b0);
        repeat (6) @(negedge clk);
        check({6'h0, secure, ublk}, {6'h0, exp_secure, exp_secure});
    endtask

    task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
        @(posedge clk);
        rst <= 1'b1; nv_opt <= o; nv_prot <= p;
        flag_exp = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        rst = 1'b1; ce = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; dbg = 1'b0;
        adr = 8'h00; dat = 32'h0; sel = 4'hF; blank_ok = 1'b0; nv_opt = 8'h00;
        nv_prot = 8'h00; key_wr = '0; cmd = '0; miscompares = 0; cmp_count = 0;
        do_reset(8'hA0, 8'hBE);
        // Options image and its decoded outputs
        wb_rd(OFS_OPTIONS, 8'hA0, 1'b0);
        check({5'h0, nored, smode, ublk}, 8'h03);
        wb_xfer(1'b1, OFS_OPTIONS, 8'h5F, 1'b0);
        wb_rd(OFS_OPTIONS, 8'hA0, 1'b0);
        wb_rd(8'h10, 8'h00, 1'b0);
        $display("test options done");
        // Page choice and key-window steering
        wb_xfer(1'b1, OFS_MAP, 8'h40, 1'b0);
        check(8'(page), 8'h01);
        wb_rd(OFS_MAP, 8'h40, 1'b0);
        sel <= 4'h0;
        wb_xfer(1'b1, OFS_MAP, 8'h00, 1'b0);
        sel <= 4'hF;
        wb_rd(OFS_MAP, 8'h40, 1'b0);
        key_byte(0, 1'b0, 1'b1);
        key_seq(1'b1, 1'b1);
        key_seq(1'b0, 1'b0);
        wb_rd(OFS_OPTIONS, 8'hA2, 1'b0);
        $display("test key done");
        // Guard loaded at reset, violation flag and its clear
        do_reset(8'hA0, 8'hBE);
        wb_rd(OFS_GUARD, 8'hBE, 1'b0);
        launch(1'b0, 1'b0, 16'hFA00, 1'b1);
        wb_rd(OFS_STATUS, 8'h21, 1'b0);
        launch(1'b0, 1'b0, 16'hF9FF, 1'b0);
        wb_xfer(1'b1, OFS_STATUS, 8'h20, 1'b0);
        flag_exp = 1'b0;
        wb_rd(OFS_STATUS, 8'h01, 1'b0);
        launch(1'b1, 1'b0, 16'h0000, 1'b1);
        wb_xfer(1'b1, OFS_GUARD, 8'hFF, 1'b0);
        wb_rd(OFS_GUARD, 8'hBE, 1'b0);
        wb_xfer(1'b1, OFS_GUARD, 8'h7D, 1'b0);
        wb_rd(OFS_GUARD, 8'h7D, 1'b0);
        wb_xfer(1'b1, OFS_GUARD, 8'hFF, 1'b1);
        wb_rd(OFS_GUARD, 8'hFF, 1'b0);
        launch(1'b1, 1'b0, 16'h0000, 1'b0);
        launch(1'b0, 1'b0, 16'h0000, 1'b0);
        $display("test guard done");
        // Flash ranges grow by 0x600 for each step down from the top code
        for (int i = 0; i < 8; i++) begin
            wb_xfer(1'b1, OFS_GUARD, {2'h3, fcode[i]}, 1'b1);
            launch(1'b0, 1'b0, flow[i], 1'b1);
            if (flow[i] != 16'h0000) begin
                launch(1'b0, 1'b0, flow[i] - 16'h1, 1'b0);
            end
        end
        // EEPROM ranges per guard code, flash left open
        for (int e = 3; e >= 0; e--) begin
            wb_xfer(1'b1, OFS_GUARD, {2'(e), 6'h3F}, 1'b1);
            if (e == 3) begin
                launch(1'b0, 1'b1, 16'h17FF, 1'b0);
            end else begin
                launch(1'b0, 1'b1, ee_low[e], 1'b1);
                launch(1'b0, 1'b1, ee_low[e] - 16'h1, 1'b0);
            end
        end
        $display("test ranges done");
        // Every lock code, then key refused and blank check unlocking
        for (int c = 0; c < 4; c++) begin
            do_reset(8'h40 | 8'(c), 8'hFF);
            check({5'h0, secure, nored, smode}, {5'h0, c != 2, 2'b10});
        end
        wb_rd(OFS_GUARD, 8'hFF, 1'b0);
        key_seq(1'b0, 1'b1);
        // A blank-check pulse while the clock enable is low must be lost
        @(posedge clk);
        ce <= 1'b0;
        blank_ok <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        blank_ok <= 1'b0;
        repeat (2) @(negedge clk);
        check({6'h0, secure, ublk}, 8'h03);
        @(posedge clk);
        blank_ok <= 1'b1;
        @(posedge clk);
        blank_ok <= 1'b0;
        repeat (2) @(negedge clk);
        check({6'h0, secure, ublk}, 8'h00);
        $display("test lock done");
        close_out();
    end
endmodule

`default_nettype wire
